// *** rtl/mie_core.sv ***
// Instruction execution core: fetch, decode, execute and cycle timing.
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/100ps

module mie_core (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire mie_pkg::mie_apb_req_s apb_req_i,
  output mie_pkg::mie_apb_rsp_s apb_rsp_o,
  output logic [mie_pkg::PC_W-1:0] rom_addr_o,
  input wire logic [15:0] rom_data_i,
  output mie_pkg::mie_ram_req_s ram_req_o,
  input wire logic [7:0] ram_rdata_i,
  input wire logic wdt_timeout_i,
  input wire logic wake_i,
  output logic wdt_clear_o,
  output logic clk_stop_o,
  output logic global_irq_enable_o
);
  import mie_pkg::*;

  mie_core_s s_r;
  mie_core_s s_nxt;
  logic exec_w;
  logic [5:0] op_w;
  logic [2:0] bsel_w;
  logic [7:0] m_w;
  logic is_op_w;
  logic [PC_W-1:0] stk_top_w;
  logic [7:0] mval;
  logic [7:0] res;
  logic [10:0] sum;
  logic wen;
  logic [7:0] wdat;
  logic skip;
  logic [1:0] extra;
  logic [PC_W-1:0] pcn;
  logic tab;
  logic [PC_W-1:0] taddr;

  // Returns {overflow, half carry, carry, sum}.
  function automatic logic [10:0] add8(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic ci);
    logic [4:0] lo;
    logic [3:0] mid;
    logic [1:0] top;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    mid = {1'b0, a[6:4]} + {1'b0, b[6:4]} + {3'h0, lo[4]};
    top = {1'b0, a[7]} + {1'b0, b[7]} + {1'b0, mid[3]};
    return {top[1] ^ mid[3], lo[4], top[1], top[0], mid[2:0], lo[3:0]};
  endfunction

  assign exec_w = (s_r.st == MIE_RUN) && (s_r.ph == PH_LAST);
  assign op_w = s_r.ir[13:8];
  assign bsel_w = s_r.ir[10:8];
  assign m_w = s_r.ir[7:0];
  assign is_op_w = (s_r.ir[15:14] == CLS_OP);
  assign stk_top_w = s_r.stk[s_r.sp - SP_STEP];

  assign rom_addr_o = s_r.rom_addr;
  assign ram_req_o = s_r.ram;
  assign wdt_clear_o = s_r.wdt_clr;
  assign clk_stop_o = (s_r.st == MIE_HALT);
  assign global_irq_enable_o = s_r.gie;
  assign apb_rsp_o.prdata = s_r.prdata;
  assign apb_rsp_o.pslverr = s_r.pslverr;
  // Read data is latched in the setup cycle, so no wait states are needed.
  assign apb_rsp_o.pready = apb_req_i.psel && apb_req_i.penable;

  always_comb begin
    s_nxt = s_r;
    mval = BYTE_ZERO;
    res = BYTE_ZERO;
    sum = 11'h000;
    wen = 1'b0;
    wdat = BYTE_ZERO;
    skip = 1'b0;
    extra = 2'h0;
    pcn = s_r.pc + PC_ONE;
    tab = 1'b0;
    taddr = s_r.pc;
    s_nxt.ram.we = 1'b0;
    s_nxt.wdt_clr = 1'b0;

    if (apb_req_i.psel && !apb_req_i.penable) begin
      s_nxt.pslverr = apb_req_i.pwrite;
      if (apb_req_i.paddr == OFS_CTRL) begin
        s_nxt.prdata = {29'h0, s_r.gie, s_r.tpage, s_r.run};
        s_nxt.pslverr = 1'b0;
      end else if (apb_req_i.paddr == OFS_STAT) begin
        s_nxt.prdata = {17'h0, s_r.st == MIE_HALT, s_r.sleep_entered_flag, s_r.to, s_r.ov,
                        s_r.z, s_r.ac, s_r.c, s_r.acc};
      end else if (apb_req_i.paddr == OFS_PC) begin
        s_nxt.prdata = {19'h0, s_r.pc};
      end else begin
        s_nxt.prdata = 32'h0000_0000;
        s_nxt.pslverr = 1'b1;
      end
    end
    if (apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite &&
        apb_req_i.paddr == OFS_CTRL) begin
      s_nxt.run = apb_req_i.pwdata[CTRL_RUN];
      s_nxt.tpage = apb_req_i.pwdata[CTRL_TPAGE];
      s_nxt.gie = apb_req_i.pwdata[CTRL_GIE];
    end

    case (s_r.st)
      MIE_RUN: begin
        if (s_r.ph != PH_FIRST || s_r.run) begin
          s_nxt.ph = s_r.ph + PH_STEP;
        end
        if (s_r.ph == PH_FETCH) begin
          s_nxt.ir = rom_data_i;
          s_nxt.ram.addr = rom_data_i[7:0];
        end
        if (exec_w) begin
          if (m_w == ADR_PCL) begin
            mval = s_r.pc[7:0];
          end else if (m_w == ADR_TABLE_PTR_LOW) begin
            mval = s_r.table_ptr_low;
          end else if (m_w == ADR_TABLE_PTR_HIGH) begin
            mval = s_r.table_ptr_high;
          end else if (m_w == ADR_TABLE_READ_HIGH) begin
            mval = s_r.table_read_high;
          end else begin
            mval = ram_rdata_i;
          end
          if (s_r.ir[15:14] == CLS_JMP) begin
            if (s_r.ir[JMP_CALL_BIT]) begin
              s_nxt.stk[s_r.sp] = s_r.pc + PC_ONE;
              s_nxt.sp = s_r.sp + SP_STEP;
            end
            pcn = s_r.ir[PC_W-1:0];
            extra = ONE_CYC;
          end else if (is_op_w) begin
            case (op_w)
              OP_NOP: begin
              end
              OP_SZ: begin
                skip = (mval == BYTE_ZERO);
              end
              OP_SZA: begin
                s_nxt.acc = mval;
                skip = (mval == BYTE_ZERO);
              end
              OP_SIZ, OP_SDZ, OP_INC_COPY_SKIP_IF_NULL, OP_DEC_COPY_SKIP_IF_NULL: begin
                if (op_w == OP_SIZ || op_w == OP_INC_COPY_SKIP_IF_NULL) begin
                  res = mval + BYTE_ONE;
                end else begin
                  res = mval - BYTE_ONE;
                end
                skip = (res == BYTE_ZERO);
                if (op_w == OP_SIZ || op_w == OP_SDZ) begin
                  wen = 1'b1;
                  wdat = res;
                end else begin
                  s_nxt.acc = res;
                end
              end
              OP_RET, OP_RETA, OP_IRQ_EXIT: begin
                s_nxt.sp = s_r.sp - SP_STEP;
                pcn = stk_top_w;
                extra = ONE_CYC;
                if (op_w == OP_RETA) begin
                  s_nxt.acc = m_w;
                end
                if (op_w == OP_IRQ_EXIT) begin
                  s_nxt.gie = 1'b1;
                end
              end
              OP_TABP: begin
                tab = 1'b1;
                if (s_r.tpage) begin
                  taddr = {s_r.table_ptr_high[4:0], s_r.table_ptr_low};
                end else begin
                  taddr = {s_r.pc[PC_W-1:8], s_r.table_ptr_low};
                end
              end
              OP_TABL: begin
                tab = 1'b1;
                taddr = {LAST_PAGE, s_r.table_ptr_low};
              end
              OP_CLR, OP_SET: begin
                wen = 1'b1;
                wdat = (op_w == OP_SET) ? BYTE_ONES : BYTE_ZERO;
              end
              OP_KICK: begin
                s_nxt.wdt_clr = 1'b1;
                s_nxt.to = 1'b0;
                s_nxt.sleep_entered_flag = 1'b0;
                s_nxt.pre1 = 1'b0;
                s_nxt.pre2 = 1'b0;
              end
              OP_PRE1, OP_PRE2: begin
                if ((op_w == OP_PRE1) ? s_r.pre2 : s_r.pre1) begin
                  s_nxt.wdt_clr = 1'b1;
                  s_nxt.to = 1'b0;
                  s_nxt.sleep_entered_flag = 1'b0;
                  s_nxt.pre1 = 1'b0;
                  s_nxt.pre2 = 1'b0;
                end else if (op_w == OP_PRE1) begin
                  s_nxt.pre1 = 1'b1;
                end else begin
                  s_nxt.pre2 = 1'b1;
                end
              end
              OP_SWAP: begin
                wen = 1'b1;
                wdat = {mval[3:0], mval[7:4]};
              end
              OP_NIBBLE_EXCHANGE_COPY: begin
                s_nxt.acc = {mval[3:0], mval[7:4]};
              end
              OP_HALT: begin
                s_nxt.st = MIE_HALT;
                s_nxt.wdt_clr = 1'b1;
                s_nxt.sleep_entered_flag = 1'b1;
                s_nxt.to = 1'b0;
              end
              OP_ADC, OP_ADD_WITH_CARRY_TO_MEM, OP_ADD, OP_SUM_TO_MEM, OP_ADDI: begin
                sum = add8(s_r.acc, (op_w == OP_ADDI) ? m_w : mval,
                           (op_w == OP_ADC || op_w == OP_ADD_WITH_CARRY_TO_MEM) && s_r.c);
                s_nxt.ov = sum[10];
                s_nxt.ac = sum[9];
                s_nxt.c = sum[8];
                s_nxt.z = (sum[7:0] == BYTE_ZERO);
                if (op_w == OP_ADD_WITH_CARRY_TO_MEM || op_w == OP_SUM_TO_MEM) begin
                  wen = 1'b1;
                  wdat = sum[7:0];
                end else begin
                  s_nxt.acc = sum[7:0];
                end
              end
              OP_AND, OP_CONJUNCTION_TO_MEM, OP_ANDI: begin
                res = s_r.acc & ((op_w == OP_ANDI) ? m_w : mval);
                s_nxt.z = (res == BYTE_ZERO);
                if (op_w == OP_CONJUNCTION_TO_MEM) begin
                  wen = 1'b1;
                  wdat = res;
                end else begin
                  s_nxt.acc = res;
                end
              end
              OP_CPL: begin
                wen = 1'b1;
                wdat = ~mval;
                s_nxt.z = (wdat == BYTE_ZERO);
              end
              default: begin
                if (op_w[5:3] == GRP_SZB) begin
                  skip = !mval[bsel_w];
                end else if (op_w[5:3] == GRP_SNZB) begin
                  skip = mval[bsel_w];
                end else if (op_w[5:3] == GRP_CLRB) begin
                  wen = 1'b1;
                  wdat = mval;
                  wdat[bsel_w] = 1'b0;
                end
              end
            endcase
          end
          if (skip) begin
            pcn = s_r.pc + PC_TWO;
            extra = extra + ONE_CYC;
          end
          if (wen && m_w == ADR_PCL) begin
            // A loaded low byte wins over the skip step.
            pcn = {s_r.pc[PC_W-1:8], wdat};
            extra = extra + ONE_CYC;
          end
          s_nxt.pc = pcn;
          s_nxt.rom_addr = pcn;
          if (tab) begin
            s_nxt.st = MIE_TABLE;
            s_nxt.rom_addr = taddr;
          end else if (op_w == OP_HALT && is_op_w) begin
            s_nxt.st = MIE_HALT;
          end else if (extra != 2'h0) begin
            s_nxt.st = MIE_STALL;
            s_nxt.stall = extra;
          end
        end
      end
      MIE_STALL: begin
        s_nxt.ph = s_r.ph + PH_STEP;
        if (s_r.ph == PH_LAST) begin
          s_nxt.stall = s_r.stall - ONE_CYC;
          if (s_r.stall == ONE_CYC) begin
            s_nxt.st = MIE_RUN;
          end
        end
      end
      MIE_TABLE: begin
        s_nxt.ph = s_r.ph + PH_STEP;
        if (s_r.ph == PH_FETCH) begin
          s_nxt.tword = rom_data_i;
        end
        if (s_r.ph == PH_LAST) begin
          wen = 1'b1;
          wdat = s_r.tword[7:0];
          s_nxt.table_read_high = s_r.tword[15:8];
          s_nxt.st = MIE_RUN;
          s_nxt.rom_addr = s_r.pc;
          if (m_w == ADR_PCL) begin
            s_nxt.pc = {s_r.pc[PC_W-1:8], wdat};
            s_nxt.rom_addr = {s_r.pc[PC_W-1:8], wdat};
            s_nxt.st = MIE_STALL;
            s_nxt.stall = ONE_CYC;
          end
        end
      end
      MIE_HALT: begin
        // The clock is stopped outside; only the wake input restarts us.
        if (wake_i) begin
          s_nxt.st = MIE_RUN;
          s_nxt.ph = PH_FIRST;
        end
      end
      default: begin
        s_nxt.st = MIE_RUN;
      end
    endcase

    if (wen) begin
      if (m_w == ADR_TABLE_PTR_LOW) begin
        s_nxt.table_ptr_low = wdat;
      end else if (m_w == ADR_TABLE_PTR_HIGH) begin
        s_nxt.table_ptr_high = wdat;
      end else if (m_w == ADR_TABLE_READ_HIGH) begin
        s_nxt.table_read_high = wdat;
      end else if (m_w != ADR_PCL) begin
        s_nxt.ram.we = 1'b1;
        s_nxt.ram.addr = m_w;
        s_nxt.ram.wdata = wdat;
      end
    end
    // A time-out in the same cycle as a clear keeps the flag set.
    if (wdt_timeout_i) begin
      s_nxt.to = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r <= '0;
      s_r.st <= MIE_RUN;
      s_r.pc <= PC_RST;
      s_r.rom_addr <= PC_RST;
      s_r.run <= RUN_RST;
      s_r.tpage <= TPAGE_RST;
      s_r.gie <= GIE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  a_jump_two_cycles: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    exec_w && s_r.ir[15:14] == CLS_JMP
    |=> (s_r.st == MIE_STALL) [*4] ##1 (s_r.st == MIE_RUN))
    else $error("Jump or call did not take two cycles.");

  a_skip_extra_cycle: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    exec_w && skip && !(wen && m_w == ADR_PCL)
    |=> s_r.st == MIE_STALL && s_r.pc == $past(s_r.pc) + PC_TWO)
    else $error("Taken skip did not add a cycle.");

  a_table_two_cycles: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    exec_w && is_op_w && (op_w == OP_TABP || op_w == OP_TABL)
    |=> (s_r.st == MIE_TABLE) [*4] ##1 (s_r.st != MIE_TABLE))
    else $error("Table read did not take two cycles.");

  a_kick_clears: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    exec_w && is_op_w && op_w == OP_KICK && !wdt_timeout_i
    |=> !s_r.to && !s_r.sleep_entered_flag && s_r.wdt_clr ##1 !s_r.wdt_clr)
    else $error("Watchdog kick failed to clear.");

  a_prekick_single: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    exec_w && is_op_w && op_w == OP_PRE1 && !s_r.pre2
    |=> s_r.pre1 && !s_r.wdt_clr && s_r.sleep_entered_flag == $past(s_r.sleep_entered_flag))
    else $error("Single pre-kick changed the watchdog.");

  a_halt_sleep: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    exec_w && is_op_w && op_w == OP_HALT && !wdt_timeout_i
    |=> s_r.sleep_entered_flag && !s_r.to && clk_stop_o && s_r.wdt_clr)
    else $error("Halt did not enter sleep correctly.");

  a_irq_exit_pop: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    exec_w && is_op_w && op_w == OP_IRQ_EXIT
    |=> s_r.gie && s_r.pc == $past(stk_top_w))
    else $error("Interrupt return did not pop and enable.");

  a_bit_clear_write: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    exec_w && is_op_w && op_w[5:3] == GRP_CLRB && m_w > ADR_TABLE_READ_HIGH
    |=> s_r.ram.we && !s_r.ram.wdata[$past(bsel_w)])
    else $error("Bit clear did not zero the bit.");
endmodule // mie_core

// *** rtl/mie_pkg.sv ***
// Shared constants and types of the instruction execution core.
package mie_pkg;
  localparam int CYC_CLKS = 4;
  localparam logic [1:0] PH_FIRST = 2'h0;
  localparam logic [1:0] PH_FETCH = 2'h1;
  localparam logic [1:0] PH_LAST = 2'(CYC_CLKS - 1);
  localparam logic [1:0] PH_STEP = 2'h1;
  localparam logic [1:0] ONE_CYC = 2'h1;
  localparam int PC_W = 13;
  localparam int STK_DEPTH = 8;
  localparam logic [2:0] SP_STEP = 3'h1;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
  localparam logic [PC_W-1:0] PC_TWO = 13'h0002;
  localparam logic [4:0] LAST_PAGE = 5'h1F;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  // Core registers that live in the data address space.
  localparam logic [7:0] ADR_PCL = 8'h06;
  localparam logic [7:0] ADR_TABLE_PTR_LOW = 8'h07;
  localparam logic [7:0] ADR_TABLE_PTR_HIGH = 8'h08;
  localparam logic [7:0] ADR_TABLE_READ_HIGH = 8'h09;
  // Instruction word classes in bits 15:14.
  localparam logic [1:0] CLS_OP = 2'h0;
  localparam logic [1:0] CLS_JMP = 2'h3;
  localparam int JMP_CALL_BIT = 13;
  localparam logic [5:0] OP_NOP = 6'h00, OP_SZ = 6'h01, OP_SZA = 6'h02;
  localparam logic [5:0] OP_SIZ = 6'h03, OP_SDZ = 6'h04, OP_INC_COPY_SKIP_IF_NULL = 6'h05;
  localparam logic [5:0] OP_DEC_COPY_SKIP_IF_NULL = 6'h06, OP_RET = 6'h07, OP_RETA = 6'h08;
  localparam logic [5:0] OP_IRQ_EXIT = 6'h09, OP_TABP = 6'h0A, OP_TABL = 6'h0B;
  localparam logic [5:0] OP_CLR = 6'h0C, OP_SET = 6'h0D, OP_KICK = 6'h0E;
  localparam logic [5:0] OP_PRE1 = 6'h0F, OP_PRE2 = 6'h10, OP_SWAP = 6'h11;
  localparam logic [5:0] OP_NIBBLE_EXCHANGE_COPY = 6'h12, OP_HALT = 6'h13, OP_ADC = 6'h14;
  localparam logic [5:0] OP_ADD_WITH_CARRY_TO_MEM = 6'h15, OP_ADD = 6'h16, OP_SUM_TO_MEM = 6'h17;
  localparam logic [5:0] OP_ADDI = 6'h18, OP_AND = 6'h19, OP_CONJUNCTION_TO_MEM = 6'h1A;
  localparam logic [5:0] OP_ANDI = 6'h1B, OP_CPL = 6'h1C;
  localparam logic [2:0] GRP_SZB = 3'h4, GRP_SNZB = 3'h5, GRP_CLRB = 3'h6;
  // Register bus map.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam int CTRL_RUN = 0, CTRL_TPAGE = 1, CTRL_GIE = 2;
  localparam logic RUN_RST = 1'b1, TPAGE_RST = 1'b0, GIE_RST = 1'b0;

  typedef enum logic [1:0] {
    MIE_RUN = 2'b00,
    MIE_STALL = 2'b01,
    MIE_TABLE = 2'b10,
    MIE_HALT = 2'b11
  } mie_state_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } mie_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mie_apb_rsp_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
  } mie_ram_req_s;

  typedef struct packed {
    mie_state_e st;
    logic [1:0] ph;
    logic [1:0] stall;
    logic [PC_W-1:0] pc;
    logic [15:0] ir;
    logic [15:0] tword;
    logic [7:0] acc;
    logic c, ac, z, ov, to, sleep_entered_flag, gie, tpage, run, pre1, pre2;
    logic [2:0] sp;
    logic [STK_DEPTH-1:0][PC_W-1:0] stk;
    logic [7:0] table_ptr_low, table_ptr_high, table_read_high;
    logic [PC_W-1:0] rom_addr;
    mie_ram_req_s ram;
    logic wdt_clr;
    logic [31:0] prdata;
    logic pslverr;
  } mie_core_s;
endpackage

// *** verif/mie_mem_model.sv ***
// Behavioural program ROM and data RAM that face the execution core.
`timescale 1ns/100ps
module mie_mem_model (
  input wire logic clk_sys_i,
  input wire logic [mie_pkg::PC_W-1:0] rom_addr_i,
  output logic [15:0] rom_data_o,
  input wire mie_pkg::mie_ram_req_s ram_req_i,
  output logic [7:0] ram_rdata_o,
  input wire logic ld_rom_i,
  input wire logic ld_ram_i,
  input wire logic [12:0] ld_addr_i,
  input wire logic [15:0] ld_data_i,
  input wire logic [7:0] peek_addr_i,
  output logic [7:0] peek_data_o
);
  import mie_pkg::*;
  logic [15:0] rom [2**PC_W];
  logic [7:0] ram [256];
  // Every word starts as a no-op, so a stray fetch cannot turn unknown.
  initial begin
    foreach (rom[k]) rom[k] = 16'h0000;
    foreach (ram[k]) ram[k] = 8'h00;
  end
  assign rom_data_o = rom[rom_addr_i];
  assign ram_rdata_o = ram[ram_req_i.addr];
  assign peek_data_o = ram[peek_addr_i];
  always @(posedge clk_sys_i) begin
    if (ld_rom_i) rom[ld_addr_i] <= ld_data_i;
    if (ld_ram_i) ram[ld_addr_i[7:0]] <= ld_data_i[7:0];
    if (ram_req_i.we) ram[ram_req_i.addr] <= ram_req_i.wdata;
  end
endmodule // mie_mem_model

// *** verif/tb.sv ***
// Self-checking testbench of the instruction execution core.
`timescale 1ns/100ps
module tb;
  import mie_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  mie_apb_req_s apb_req = '0;
  mie_apb_rsp_s apb_rsp;
  logic [PC_W-1:0] rom_addr;
  logic [15:0] rom_data;
  mie_ram_req_s ram_req;
  logic [7:0] ram_rdata;
  logic [7:0] peek_data;
  logic [7:0] peek_addr = 8'h00;
  logic wdt_to = 1'b0;
  logic wdt_clr;
  logic clk_stop;
  logic gie;
  logic ld_rom = 1'b0;
  logic ld_ram = 1'b0;
  logic [12:0] ld_addr = 13'h0000;
  logic [15:0] ld_data = 16'h0000;
  logic [31:0] rd;
  logic e;
  int num_errors = 0;
  int n_tests = 0;
  int n_clr = 0;
  int n;

  mie_core mie_core_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .apb_req_i(apb_req), .apb_rsp_o(apb_rsp), .rom_addr_o(rom_addr),
    .rom_data_i(rom_data), .ram_req_o(ram_req), .ram_rdata_i(ram_rdata),
    .wdt_timeout_i(wdt_to), .wake_i(1'b0), .wdt_clear_o(wdt_clr),
    .clk_stop_o(clk_stop), .global_irq_enable_o(gie));
  mie_mem_model mie_mem_model_i (.clk_sys_i(clk_sys_i),
    .rom_addr_i(rom_addr), .rom_data_o(rom_data), .ram_req_i(ram_req),
    .ram_rdata_o(ram_rdata), .ld_rom_i(ld_rom), .ld_ram_i(ld_ram),
    .ld_addr_i(ld_addr), .ld_data_i(ld_data), .peek_addr_i(peek_addr),
    .peek_data_o(peek_data));

  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    if (wdt_clr === 1'b1) n_clr++;
  end

  task automatic end_sim();
    if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tmo();
    num_errors++;
    $display("Error at %0t: wait ran out", $time);
    end_sim();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    int k;
    @(posedge clk_sys_i);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_sys_i);
    apb_req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys_i);
      if (++k > 20) tmo();
    end while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  task automatic boot(input logic [31:0] p[$], input logic [15:0] m[$]);
    rst_b_i <= 1'b0;
    foreach (p[k]) begin
      @(posedge clk_sys_i);
      ld_rom <= 1'b1;
      ld_addr <= p[k][28:16];
      ld_data <= p[k][15:0];
    end
    foreach (m[k]) begin
      @(posedge clk_sys_i);
      ld_rom <= 1'b0;
      ld_ram <= 1'b1;
      ld_addr <= {5'h00, m[k][15:8]};
      ld_data <= {8'h00, m[k][7:0]};
    end
    @(posedge clk_sys_i);
    ld_rom <= 1'b0;
    ld_ram <= 1'b0;
    @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    n_clr = 0;
  endtask
  task automatic wait_pc(input int a, output int c);
    c = 0;
    while (rom_addr !== 13'(a)) begin
      @(posedge clk_sys_i);
      if (++c > 99) tmo();
    end
  endtask
  // The fetch address moves at execute, before any stall, so an
  // instruction's length is timed from its execute edge to the next one.
  task automatic wait_exec(input int a, output int c);
    c = 0;
    while (!(mie_core_i.exec_w === 1'b1 && rom_addr === 13'(a))) begin
      @(posedge clk_sys_i);
      if (++c > 99) tmo();
    end
  endtask
  // Triples of address, next address and clocks between their executes.
  task automatic steps(input int s[$]);
    int c;
    for (int k = 0; k < s.size(); k += 3) begin
      wait_exec(s[k], c);
      wait_exec(s[k+1], c);
      chk(32'(c), 32'(s[k+2]));
    end
  endtask
  task automatic peek(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk_sys_i);
    peek_addr <= a;
    @(posedge clk_sys_i);
    chk(32'(peek_data), 32'(x));
  endtask

  task automatic t_branch();
    boot('{32'h0000_E010, 32'h0001_E011, 32'h0002_E012, 32'h0003_C003,
      32'h0010_0700, 32'h0011_085A, 32'h0012_0900}, '{16'h0000});
    steps('{8'h00, 8'h10, 8'h08, 8'h10, 8'h01, 8'h08, 8'h01, 8'h11,
      8'h08, 8'h11, 8'h02, 8'h08, 8'h02, 8'h12, 8'h08, 8'h12, 8'h03,
      8'h08});
    chk(32'(gie), 32'h0000_0001);
    apb(1'b0, OFS_STAT, '0, rd, e);
    chk(32'(rd[7:0]), 32'h0000_005A);
  endtask
  task automatic t_skip();
    boot('{32'h0000_0120, 32'h0002_0121, 32'h0003_0222, 32'h0004_0322,
      32'h0006_0623, 32'h0008_2F24, 32'h000A_2724, 32'h000B_2024,
      32'h000D_0425, 32'h000F_C00F}, '{16'h2000, 16'h2105, 16'h22FF,
      16'h2301, 16'h2480, 16'h2501});
    steps('{8'h00, 8'h02, 8'h08, 8'h02, 8'h03, 8'h04, 8'h03, 8'h04, 8'h04,
      8'h04, 8'h06, 8'h08, 8'h06, 8'h08, 8'h08, 8'h08, 8'h0A, 8'h08,
      8'h0A, 8'h0B, 8'h04, 8'h0B, 8'h0D, 8'h08, 8'h0D, 8'h0F,
      8'h08});
    peek(8'h22, 8'h00);
    peek(8'h23, 8'h01);
    peek(8'h25, 8'h00);
    apb(1'b0, OFS_STAT, '0, rd, e);
    chk(32'(rd[7:0]), 32'h0000_0000);
    apb(1'b0, OFS_CTRL, '0, rd, e);
    chk(rd, 32'h0000_0001);
    apb(1'b0, 8'h0C, '0, rd, e);
    chk({rd[30:0], e}, 32'h0000_0001);
    apb(1'b1, OFS_PC, 32'h0000_0055, rd, e);
    chk(32'(e), 32'h0000_0001);
  endtask
  task automatic t_table(input logic tp);
    boot('{32'h0000_0C07, 32'h0001_0D08, 32'h0002_0A40, 32'h0003_0B41,
      32'h0004_1130, 32'h0005_1231, 32'h0006_1A34, 32'h0007_3532,
      32'h0008_1C33, 32'h0009_0209, 32'h000A_0D06, 32'h00FF_C0FF,
      32'h1F00_BEEF}, '{16'h303C, 16'h31A5, 16'h3277, 16'h330F,
      16'h34FF, 16'h4000, 16'h4100});
    // Paging must be on before the table read two instructions later.
    if (tp) apb(1'b1, OFS_CTRL, 32'h0000_0003, rd, e);
    steps('{8'h02, 8'h03, 8'h08, 8'h03, 8'h04, 8'h08, 8'h05, 8'h06, 8'h04,
      8'h0A, 8'hFF, 8'h08});
    peek(8'h40, tp ? 8'hEF : 8'h07);
    peek(8'h41, 8'hEF);
    peek(8'h30, 8'hC3);
    peek(8'h31, 8'hA5);
    peek(8'h34, 8'h5A);
    peek(8'h32, 8'h57);
    peek(8'h33, 8'hF0);
    apb(1'b0, OFS_STAT, '0, rd, e);
    chk(32'(rd[10:0]), 32'h0000_00BE);
  endtask
  task automatic t_arith();
    boot('{32'h0000_18FF, 32'h0001_1751, 32'h0002_1801, 32'h0003_1A52,
      32'h0004_1553, 32'h0005_1654, 32'h0006_1801, 32'h0007_1956,
      32'h0008_0F00, 32'h0009_0F00, 32'h000A_1000, 32'h000B_0E00,
      32'h000C_1300}, '{16'h5180, 16'h525A, 16'h530E, 16'h547F,
      16'h56FF});
    @(posedge clk_sys_i);
    wdt_to <= 1'b1;
    @(posedge clk_sys_i);
    wdt_to <= 1'b0;
    steps('{8'h08, 8'h09, 8'h04});
    apb(1'b0, OFS_STAT, '0, rd, e);
    chk({rd[13:12], 30'(n_clr)}, 32'h4000_0000);
    wait_pc(8'h0C, n);
    n = 0;
    while (clk_stop !== 1'b1) begin
      @(posedge clk_sys_i);
      if (++n > 99) tmo();
    end
    apb(1'b0, OFS_STAT, '0, rd, e);
    chk(rd, 32'h0000_6A80);
    chk(32'(n_clr), 32'h0000_0003);
    peek(8'h51, 8'h7F);
    peek(8'h52, 8'h00);
    peek(8'h53, 8'h0F);
  endtask

  initial begin
    repeat (5) @(posedge clk_sys_i);
    t_branch();
    t_skip();
    t_table(1'b0);
    t_table(1'b1);
    t_arith();
    end_sim();
  end
endmodule // tb
